// ---- rtl/sats_buf2.sv ----
// two-entry result buffer with valid/ready on both sides
`timescale 1ns/100ps
`default_nettype none
module sats_buf2 (
    input wire logic clk,
    input wire logic srst,
    sats_buf_if.dst in_b,
    output logic [9:0] out_data,
    output logic out_valid,
    input wire logic out_ready
);
    typedef struct packed {
        logic [1:0][9:0] mem;
        logic [1:0] cnt;
    } sats_buf_state_t;
    sats_buf_state_t st_r, st_nxt;
    logic push, pop;
    assign in_b.ready = (st_r.cnt != 2'h2);
    assign out_valid = (st_r.cnt != 2'h0);
    assign out_data = st_r.mem[0];
    assign push = in_b.valid && in_b.ready;
    assign pop = out_valid && out_ready;
    always_comb begin
        st_nxt = st_r;
        if (pop) begin
            st_nxt.mem[0] = st_r.mem[1];
            st_nxt.cnt = st_r.cnt - 2'h1;
        end
        if (push) begin
            st_nxt.mem[st_nxt.cnt[0]] = in_b.data;
            st_nxt.cnt = st_nxt.cnt + 2'h1;
        end
    end
    always_ff @(posedge clk) begin
        if (srst) begin
            st_r <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end
endmodule
`default_nettype wire

// ---- rtl/sats_buf_if.sv ----
// result hand-over carrier between conversion logic and the two-entry buffer
`timescale 1ns/100ps
`default_nettype none
interface sats_buf_if;
    logic [9:0] data;
    logic valid;
    logic ready;
    modport src (output data, output valid, input ready);
    modport dst (input data, input valid, output ready);
endinterface
`default_nettype wire

// ---- rtl/sats_pkg.sv ----
// types for the serial converter sequencer
package sats_pkg;
    typedef logic [9:0] sats_code_t;
    typedef enum logic [3:0] {
        SATS_IDLE = 4'b0001,
        SATS_SAMPLE = 4'b0010,
        SATS_CONV = 4'b0100,
        SATS_HOLD = 4'b1000
    } sats_state_t;
endpackage

// ---- rtl/sats_regs.svh ----
// timing constants and field widths for the serial converter sequencer
`ifndef SATS_REGS_SVH
`define SATS_REGS_SVH
`define SATS_CLK_NS 25
`define SATS_CONV_NS 21000
// conversion cycles: longest time, rounded down
`define SATS_CONV_CYC (`SATS_CONV_NS / `SATS_CLK_NS)
`define SATS_DEGLITCH_NS 1425
// select qualification: least time, rounded up
`define SATS_DEGLITCH_CYC ((`SATS_DEGLITCH_NS + `SATS_CLK_NS - 1) / `SATS_CLK_NS)
`define SATS_ABORT_NS 9000
`define SATS_ABORT_CYC (`SATS_ABORT_NS / `SATS_CLK_NS)
`define SATS_RES_BITS 10
`define SATS_SAMPLE_START 3
`define SATS_SAMPLE_END 10
`define SATS_FRAME_MAX 16
`define SATS_CODE_MAX 10'h3ff
`define SATS_CODE_MIN 10'h000
`endif

// ---- rtl/sats_top.sv ----
// serial-output converter transfer sequencer: select deglitch, shift, sample, convert
//
// Functional notes
// - sample from third to tenth falling shift edge
// - conversion finishes within 21 us
// - full cycle within 21 us plus ten
// - select change valid after 1.425 us hold
// - select high stops shift response promptly
// - select low within 9 us aborts conversion
// - select fall drives msb immediately
// - select rise releases data output
// - next bit after each falling shift edge
// - out-of-range inputs clamp to end codes
// - select-framed transfers of ten to sixteen clocks
// - continuous sixteen-clock mode, select held low
`timescale 1ns/100ps
`include "sats_regs.svh"
`default_nettype none
module sats_top
    import sats_pkg::*;
(
    input wire logic CLOCK,
    input wire logic SRST,
    input wire logic SHIFT_CLK,
    input wire logic SEL_N,
    input wire logic [9:0] ANALOG_CODE,
    input wire logic ANALOG_OVER,
    input wire logic ANALOG_UNDER,
    output logic DOUT_O,
    output logic DOUT_OE,
    output logic SAMPLING,
    output logic CONV_BUSY,
    output logic [9:0] RESULT_DATA,
    output logic RESULT_VALID,
    input wire logic RESULT_READY
);
    import sats_pkg::*;

    // ********************************************
    // shift-clock domain
    // ********************************************
    // link side only sees select once qualified in the core domain
    logic [9:0] lk_shift_r;
    logic [4:0] lk_fall_r;
    logic lk_samp_r;
    logic [9:0] lk_word;
    logic lk_en;
    // the shift clock stops between frames, so a synchroniser on it would never settle;
    // the qualified enable and the result word are levels that are settled long before
    // the host's first edge (select setup, no shifting during conversion), and a frame
    // cut by select clears the link state at once through the asynchronous clear
    always_ff @(negedge SHIFT_CLK or negedge lk_en) begin
        if (!lk_en) begin
            lk_fall_r <= 5'h00;
            lk_samp_r <= 1'b0;
            lk_shift_r <= 10'h000;
        end else begin
            if (lk_fall_r == 5'(`SATS_FRAME_MAX - 1)) begin
                lk_fall_r <= 5'h00;
            end else begin
                lk_fall_r <= lk_fall_r + 5'h01;
            end
            // sampling is a level, so no false edge can follow a reset
            if (lk_fall_r == 5'(`SATS_SAMPLE_START - 1)) begin
                lk_samp_r <= 1'b1;
            end else if (lk_fall_r == 5'(`SATS_SAMPLE_END - 1)) begin
                lk_samp_r <= 1'b0;
            end
            if (lk_fall_r == 5'h00) begin
                lk_shift_r <= {lk_word[8:0], 1'b0};
            end else begin
                lk_shift_r <= {lk_shift_r[8:0], 1'b0};
            end
        end
    end

    // ********************************************
    // core domain
    // ********************************************
    typedef struct packed {
        sats_state_t st;
        logic sel_s1;
        logic sel_s2;
        logic sel_q;
        logic [6:0] dg_cnt;
        logic [9:0] conv_cnt;
        logic [8:0] abort_cnt;
        logic [2:0] tog_sync;
        logic [9:0] result;
        logic push;
        logic dout_oe;
    } sats_core_t;
    sats_core_t c_r, c_nxt;
    sats_buf_if bif();
    logic samp_rise;
    logic samp_fall;
    sats_code_t clamped;

    // edges are taken behind the second sync stage only
    assign samp_rise = c_r.tog_sync[1] && !c_r.tog_sync[2];
    assign samp_fall = !c_r.tog_sync[1] && c_r.tog_sync[2];
    always_comb begin
        clamped = ANALOG_CODE;
        if (ANALOG_OVER) begin
            clamped = `SATS_CODE_MAX;
        end else if (ANALOG_UNDER) begin
            clamped = `SATS_CODE_MIN;
        end
    end

    always_comb begin
        c_nxt = c_r;
        c_nxt.sel_s1 = SEL_N;
        c_nxt.sel_s2 = c_r.sel_s1;
        c_nxt.tog_sync = {c_r.tog_sync[1:0], lk_samp_r};
        c_nxt.push = 1'b0;
        if (c_r.sel_s2 != c_r.sel_q) begin
            if (c_r.dg_cnt == 7'(`SATS_DEGLITCH_CYC - 1)) begin
                c_nxt.sel_q = c_r.sel_s2;
                c_nxt.dg_cnt = 7'h0;
            end else begin
                c_nxt.dg_cnt = c_r.dg_cnt + 7'h1;
            end
        end else begin
            c_nxt.dg_cnt = 7'h0;
        end
        // data output enable follows synchronised select, not the qualified one: drive msb at once, release at once
        c_nxt.dout_oe = !c_r.sel_s2;
        if (c_r.abort_cnt != 9'h0) begin
            c_nxt.abort_cnt = c_r.abort_cnt - 9'h1;
        end
        case (c_r.st)
            SATS_IDLE: begin
                if (samp_rise) begin
                    c_nxt.st = SATS_SAMPLE;
                end
            end
            SATS_SAMPLE: begin
                if (samp_fall) begin
                    c_nxt.st = SATS_CONV;
                    c_nxt.conv_cnt = 10'h0;
                    c_nxt.abort_cnt = 9'(`SATS_ABORT_CYC);
                end
            end
            SATS_CONV: begin
                c_nxt.conv_cnt = c_r.conv_cnt + 10'h1;
                if (c_r.sel_q && !c_nxt.sel_q && c_r.abort_cnt != 9'h0) begin
                    c_nxt.st = SATS_IDLE;
                end else if (c_r.conv_cnt == 10'(`SATS_CONV_CYC - 1)) begin
                    c_nxt.result = clamped;
                    c_nxt.st = SATS_HOLD;
                end
            end
            SATS_HOLD: begin
                c_nxt.push = 1'b1;
                if (bif.ready) begin
                    c_nxt.push = 1'b0;
                    c_nxt.st = SATS_IDLE;
                end
            end
            default: begin
                c_nxt.st = SATS_IDLE;
            end
        endcase
    end

    always_ff @(posedge CLOCK) begin
        if (SRST) begin
            c_r <= '0;
            c_r.st <= SATS_IDLE;
            c_r.sel_s1 <= 1'b1;
            c_r.sel_s2 <= 1'b1;
            c_r.sel_q <= 1'b1;
        end else begin
            c_r <= c_nxt;
        end
    end

    assign bif.data = c_r.result;
    assign bif.valid = (c_r.st == SATS_HOLD);
    assign lk_en = !c_r.sel_q;
    assign lk_word = c_r.result;

    sats_buf2 u_buf (
        .clk(CLOCK),
        .srst(SRST),
        .in_b(bif.dst),
        .out_data(RESULT_DATA),
        .out_valid(RESULT_VALID),
        .out_ready(RESULT_READY)
    );

    // msb comes straight from the held word before the first falling edge
    assign DOUT_O = (lk_fall_r == 5'h00) ? c_r.result[9] : lk_shift_r[9];
    assign DOUT_OE = c_r.dout_oe;
    assign SAMPLING = (c_r.st == SATS_SAMPLE);
    assign CONV_BUSY = (c_r.st == SATS_CONV);


    // ********************************************
    // checks
    // ********************************************
    // core-domain checks first, then the link-domain ones on the falling shift edge
    AST_CONV_LEN: assert property (@(posedge CLOCK) disable iff (SRST)
        $rose(c_r.st == SATS_CONV) |-> ##[1:840] (c_r.st != SATS_CONV))
        else $error("conversion overran");
    AST_DOUT_REL: assert property (@(posedge CLOCK) disable iff (SRST)
        c_r.sel_s2 |=> !DOUT_OE)
        else $error("data output not released");
    AST_DOUT_EN: assert property (@(posedge CLOCK) disable iff (SRST)
        !c_r.sel_s2 |=> DOUT_OE)
        else $error("data output not enabled");
    AST_SEL_QUAL: assert property (@(posedge CLOCK) disable iff (SRST)
        $changed(c_r.sel_q) |-> $past(c_r.sel_s2) == c_r.sel_q)
        else $error("select qualified wrongly");
    AST_CLAMP_HI: assert property (@(posedge CLOCK) disable iff (SRST)
        ANALOG_OVER |-> clamped == `SATS_CODE_MAX)
        else $error("over-range not clamped");
    AST_CLAMP_LO: assert property (@(posedge CLOCK) disable iff (SRST)
        (ANALOG_UNDER && !ANALOG_OVER) |-> clamped == `SATS_CODE_MIN)
        else $error("under-range not clamped");
    AST_HOLD_PUSH: assert property (@(posedge CLOCK) disable iff (SRST)
        (c_r.st == SATS_HOLD && bif.ready) |=> c_r.st == SATS_IDLE)
        else $error("hold state stuck");
    AST_ABORT: assert property (@(posedge CLOCK) disable iff (SRST)
        (c_r.st == SATS_CONV && c_r.sel_q && !c_nxt.sel_q && c_r.abort_cnt != 9'h0)
        |=> c_r.st == SATS_IDLE)
        else $error("abort ignored");
    AST_SAMP_ENTRY: assert property (@(posedge CLOCK) disable iff (SRST)
        (c_r.st == SATS_IDLE && samp_rise) |=> c_r.st == SATS_SAMPLE)
        else $error("sampling not entered");
    AST_SAMP_EXIT: assert property (@(posedge CLOCK) disable iff (SRST)
        (c_r.st == SATS_SAMPLE && samp_fall) |=> c_r.st == SATS_CONV)
        else $error("conversion not started");
    AST_CONV_DONE: assert property (@(posedge CLOCK) disable iff (SRST)
        (c_r.st == SATS_HOLD) |-> c_r.conv_cnt == 10'(`SATS_CONV_CYC))
        else $error("result held before full conversion");
    AST_ABORT_LOAD: assert property (@(posedge CLOCK) disable iff (SRST)
        (c_r.st == SATS_SAMPLE && c_nxt.st == SATS_CONV) |=> c_r.abort_cnt == 9'(`SATS_ABORT_CYC))
        else $error("abort window not armed");
    AST_ABORT_WIN: assert property (@(posedge CLOCK) disable iff (SRST)
        (c_r.st == SATS_CONV && c_nxt.st == SATS_IDLE) |-> c_r.abort_cnt != 9'h0)
        else $error("abort outside window");
    AST_DG_LEN: assert property (@(posedge CLOCK) disable iff (SRST)
        $changed(c_r.sel_q) |-> $past(c_r.dg_cnt) == 7'(`SATS_DEGLITCH_CYC - 1))
        else $error("select qualified too early");
    AST_DG_CLEAR: assert property (@(posedge CLOCK) disable iff (SRST)
        (c_r.sel_s2 == c_r.sel_q) |=> c_r.dg_cnt == 7'h0)
        else $error("deglitch count not cleared");
    AST_HOLD_DATA: assert property (@(posedge CLOCK) disable iff (SRST)
        (bif.valid && !bif.ready) |=> $stable(bif.data))
        else $error("held result changed");
    AST_VALID_HOLD: assert property (@(posedge CLOCK) disable iff (SRST)
        (RESULT_VALID && !RESULT_READY) |=> RESULT_VALID && $stable(RESULT_DATA))
        else $error("buffered result dropped");
    AST_LK_SAMP_ON: assert property (@(negedge SHIFT_CLK) disable iff (!lk_en)
        (lk_fall_r == 5'(`SATS_SAMPLE_START - 1)) |=> lk_samp_r)
        else $error("sampling not begun at third edge");
    AST_LK_SAMP_OFF: assert property (@(negedge SHIFT_CLK) disable iff (!lk_en)
        (lk_fall_r == 5'(`SATS_SAMPLE_END - 1)) |=> !lk_samp_r)
        else $error("sampling not ended at tenth edge");
    AST_LK_WRAP: assert property (@(negedge SHIFT_CLK) disable iff (!lk_en)
        (lk_fall_r == 5'(`SATS_FRAME_MAX - 1)) |=> lk_fall_r == 5'h00)
        else $error("sixteen-clock frame not closed");
    AST_LK_TAIL: assert property (@(negedge SHIFT_CLK) disable iff (!lk_en)
        (lk_fall_r >= 5'(`SATS_SAMPLE_END)) |-> !lk_shift_r[9])
        else $error("bit beyond tenth not low");
endmodule
`default_nettype wire

// ---- testbench/sats_host_model.sv ----
// host serial-port model: drives select and shift clock, reads data out
`timescale 1ns/100ps
`default_nettype none
module sats_host_model (
    output var logic SEL_N,
    output var logic SHIFT_CLK,
    input wire logic DOUT_O,
    input wire logic DOUT_OE
);
    logic [15:0] cap;
    initial begin
        SEL_N = 1'b1;
        SHIFT_CLK = 1'b0;
        cap = 16'h0000;
    end
    // hold every select level past qualification before shifting
    task automatic set_sel(input logic v);
        SEL_N = v;
        #2000;
    endtask
    // shift clock runs only during shift calls, 64 ns period
    task automatic shift(input int n);
        for (int i = 0; i < n; i++) begin
            #32 SHIFT_CLK = 1'b1;
            cap = {cap[14:0], DOUT_OE ? DOUT_O : 1'bx}; // sample on rising edge
            #32 SHIFT_CLK = 1'b0;
        end
    endtask
endmodule
`default_nettype wire

// ---- testbench/sats_top_tb.sv ----
// self-checking bench for the serial converter sequencer
`timescale 1ns/100ps
`default_nettype none
module sats_top_tb;
    logic clock = 1'b0;
    logic srst, over, under, ready;
    logic [9:0] code;
    wire sel_n, sclk, dout, oe, samp, busy, rvalid;
    wire [9:0] rdata;
    int failures = 0, samples_checked = 0, cyc = 0, busy_cnt = 0, busy_max = 0;
    logic saw_samp = 1'b0;
    always #12.5 clock = ~clock;
    sats_top i_dut (.CLOCK(clock), .SRST(srst), .SHIFT_CLK(sclk), .SEL_N(sel_n),
        .ANALOG_CODE(code), .ANALOG_OVER(over), .ANALOG_UNDER(under), .DOUT_O(dout),
        .DOUT_OE(oe), .SAMPLING(samp), .CONV_BUSY(busy), .RESULT_DATA(rdata),
        .RESULT_VALID(rvalid), .RESULT_READY(ready));
    sats_host_model i_host (.SEL_N(sel_n), .SHIFT_CLK(sclk), .DOUT_O(dout), .DOUT_OE(oe));
    // *****************************
    // checking helpers
    // *****************************
    task automatic chk_code(input string name, input logic [9:0] exp, input logic [9:0] got);
        samples_checked++;
        if (got !== exp) begin
            failures++;
            $display("[ERR] %s expected %h seen %h", name, exp, got);
        end
    endtask
    task automatic chk_bit(input string name, input logic exp, input logic got);
        samples_checked++;
        if (got !== exp) begin
            failures++;
            $display("[ERR] %s expected %b seen %b", name, exp, got);
        end
    endtask
    task automatic end_of_test();
        $display("checks %0d mismatches %0d", samples_checked, failures);
        if (failures == 0 && samples_checked > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask
    // hang guard: whole run needs about 7300 cycles
    always @(posedge clock) begin
        cyc++;
        busy_cnt = (busy === 1'b1) ? busy_cnt + 1 : 0;
        if (busy_cnt > busy_max) busy_max = busy_cnt;
        if (samp === 1'b1) saw_samp = 1'b1;
        if (cyc == 30000) begin
            failures++;
            end_of_test();
        end
    end
    task automatic wait_busy_end();
        for (int n = 0; n < 2000 && busy !== 1'b0; n++) @(negedge clock);
        chk_bit("conv_busy", 1'b0, busy); // next frame only after conversion
    endtask
    task automatic get_result(input logic [9:0] exp);
        for (int n = 0; n < 1500 && rvalid !== 1'b1; n++) @(negedge clock);
        chk_bit("result_valid", 1'b1, rvalid);
        chk_code("result_data", exp, rdata);
        @(posedge clock);
        @(negedge clock);
    endtask
    task automatic frame10(input logic [9:0] c);
        @(negedge clock);
        code = c;
        i_host.set_sel(1'b0);
        i_host.shift(10);
        i_host.set_sel(1'b1);
        wait_busy_end();
    endtask
    // *****************************
    // scenarios
    // *****************************
    task automatic test_ten();
        saw_samp = 1'b0;
        frame10(10'h2aa);
        chk_bit("sampling_seen", 1'b1, saw_samp);
        chk_bit("dout_oe_idle", 1'b0, oe);
        chk_bit("conv_in_time", 1'b1, busy_max <= 840);
        get_result(10'h2aa);
        $display("test ten_clock done");
    endtask
    task automatic test_long();
        @(negedge clock);
        over = 1'b1;
        under = 1'b1;
        i_host.set_sel(1'b0);
        chk_bit("dout_oe_on", 1'b1, oe);
        i_host.shift(16);
        chk_code("serial_word", 10'h2aa, i_host.cap[15:6]);
        i_host.set_sel(1'b1);
        wait_busy_end();
        get_result(10'h3ff);
        $display("test sixteen_clock done");
    endtask
    task automatic test_cont();
        @(negedge clock);
        over = 1'b0;
        i_host.set_sel(1'b0);
        i_host.shift(16);
        chk_code("serial_cont", 10'h3ff, i_host.cap[15:6]);
        wait_busy_end();
        get_result(10'h000);
        @(negedge clock);
        under = 1'b0;
        code = 10'h155;
        i_host.shift(16);
        wait_busy_end();
        get_result(10'h155);
        i_host.set_sel(1'b1);
        $display("test continuous done");
    endtask
    task automatic test_abort();
        logic seen;
        seen = 1'b0;
        @(negedge clock);
        code = 10'h0ff;
        i_host.set_sel(1'b0);
        i_host.shift(10);
        i_host.set_sel(1'b1);
        i_host.set_sel(1'b0);
        for (int n = 0; n < 1200; n++) begin
            @(negedge clock);
            if (rvalid === 1'b1) seen = 1'b1;
        end
        chk_bit("abort_result", 1'b0, seen);
        i_host.set_sel(1'b1);
        i_host.shift(10);
        repeat (4) @(negedge clock);
        chk_bit("shift_ignored", 1'b0, busy);
        $display("test abort done");
    endtask
    task automatic test_stall();
        @(negedge clock);
        ready = 1'b0;
        frame10(10'h011);
        frame10(10'h022);
        chk_bit("stall_valid", 1'b1, rvalid);
        chk_code("stall_head", 10'h011, rdata);
        ready = 1'b1;
        get_result(10'h011);
        get_result(10'h022);
        chk_bit("drained", 1'b0, rvalid);
        $display("test stall done");
    endtask
    initial begin
        srst = 1'b1;
        over = 1'b0;
        under = 1'b0;
        ready = 1'b1;
        code = 10'h001;
        repeat (3) @(posedge clock);
        @(negedge clock);
        srst = 1'b0;
        test_ten();
        test_long();
        test_cont();
        test_abort();
        test_stall();
        end_of_test();
    end
endmodule
`default_nettype wire
